//--- radio_irq_pkg.sv
// constants shared by the radio interrupt enable block
package radio_irq_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int SAMPLE_W = 7;

	// register byte offsets
	localparam logic [11:0] OFS_INTERRUPT_ENABLE_SET = 12'h304;
	localparam logic [11:0] OFS_EVENT_STATUS = 12'h100;
	localparam logic [11:0] OFS_BIT_COUNT_COMPARE = 12'h200;
	localparam logic [11:0] OFS_STRENGTH_SAMPLE_VALUE = 12'h204;

	// event bit positions, shared by status and enable layouts
	localparam int BIT_ADDRESS = 1;
	localparam int BIT_PAYLOAD = 2;
	localparam int BIT_END = 3;
	localparam int BIT_DISABLED = 4;
	localparam int BIT_DEVICE_ADDRESS_MATCH = 5;
	localparam int BIT_DEVICE_ADDRESS_MISS = 6;
	localparam int BIT_STRENGTH_SAMPLE_DONE = 7;
	localparam int BIT_BIT_COUNT_MATCH = 10;
	localparam int BIT_CHECKSUM_GOOD = 12;
	localparam int BIT_CHECKSUM_FAILED = 13;
	localparam int BIT_FRAME_BEGIN = 14;
	localparam int BIT_ENERGY_DETECT_FINISHED = 15;

	// implemented event bits; all others read as zero
	localparam logic [31:0] EVENT_MASK = 32'h0000f4fe;

	// values after reset
	localparam logic [31:0] RST_INTERRUPT_ENABLE_SET = 32'h00000000;
	localparam logic [31:0] RST_EVENT_STATUS = 32'h00000000;
	localparam logic [31:0] RST_BIT_COUNT_COMPARE = 32'h00000000;
	localparam logic [6:0] RST_STRENGTH_SAMPLE_VALUE = 7'h00;
endpackage

//--- radio_event_if.sv
// event carrier between the measurement units and the register block
`timescale 1ns/1ps
interface radio_event_if;
	logic strength_sample_done;
	logic [6:0] strength_sample_value;
	logic bit_count_match;

	modport strength_src (output strength_sample_done, output strength_sample_value);
	modport count_src (output bit_count_match);
	modport sink (input strength_sample_done, input strength_sample_value,
		input bit_count_match);
endinterface

//--- strength_sampler.sv
// captures received strength samples and flags each fresh one
`timescale 1ns/1ps
module strength_sampler
	import radio_irq_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// sample source
	input wire logic sample_strobe,
	input wire logic [6:0] sample_in,
	// to register block
	radio_event_if.strength_src evt
);
	typedef struct packed {
		logic [6:0] value;
		logic done;
	} sampler_state_t;

	sampler_state_t st_r;
	sampler_state_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		if (sample_strobe)
		begin
			// value is stored in the same edge the done pulse rises, so it is readable
			st_nxt.value = sample_in;
			st_nxt.done = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			st_r <= '{value: RST_STRENGTH_SAMPLE_VALUE, done: 1'b0};
		else
			st_r <= st_nxt;
	end

	assign evt.strength_sample_done = st_r.done;
	assign evt.strength_sample_value = st_r.value;
endmodule

//--- bit_counter.sv
// received bit counter with compare match pulse
`timescale 1ns/1ps
module bit_counter
	import radio_irq_pkg::*;
#(
	parameter int CNT_W = 32
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// receive side
	input wire logic count_start,
	input wire logic bit_strobe,
	input wire logic [CNT_W-1:0] compare,
	// to register block
	radio_event_if.count_src evt
);
	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic counting;
		logic match;
	} counter_state_t;

	counter_state_t st_r;
	counter_state_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.match = 1'b0;
		if (count_start)
		begin
			st_nxt.count = '0;
			st_nxt.counting = 1'b1;
		end
		else if (st_r.counting && bit_strobe)
		begin
			st_nxt.count = CNT_W'(st_r.count + 1'b1);
			// fires once on reaching the compare value; counting carries on
			st_nxt.match = (st_nxt.count == compare);
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			st_r <= '{count: '0, counting: 1'b0, match: 1'b0};
		else
			st_r <= st_nxt;
	end

	assign evt.bit_count_match = st_r.match;
endmodule

//--- radio_interrupt_enable_set.sv
// radio interrupt enable set register with event status and interrupt line
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module radio_interrupt_enable_set
	import radio_irq_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// register port
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// radio event pulses
	input wire logic address_evt,
	input wire logic payload_evt,
	input wire logic end_evt,
	input wire logic disabled_evt,
	input wire logic device_address_match_evt,
	input wire logic device_address_miss_evt,
	input wire logic checksum_good_evt,
	input wire logic checksum_failed_evt,
	input wire logic frame_begin_evt,
	input wire logic energy_detect_finished_evt,
	// bit counter source
	input wire logic bit_count_start,
	input wire logic rx_bit_strobe,
	// strength sample source
	input wire logic sample_strobe,
	input wire logic [6:0] sample_in,
	// interrupt
	output logic irq
);
	typedef struct packed {
		logic [31:0] enable;
		logic [31:0] status;
		logic [31:0] compare;
		logic [31:0] rdata;
		logic irq;
	} regs_state_t;

	regs_state_t st_r;
	regs_state_t st_nxt;
	logic [31:0] events;
	logic [31:0] rd_mux;

	radio_event_if evt_bus ();

	strength_sampler u_sampler (
		.clock(clock),
		.rst_n(rst_n),
		.sample_strobe(sample_strobe),
		.sample_in(sample_in),
		.evt(evt_bus.strength_src)
	);

	bit_counter #(.CNT_W(DATA_W)) u_counter (
		.clock(clock),
		.rst_n(rst_n),
		.count_start(bit_count_start),
		.bit_strobe(rx_bit_strobe),
		.compare(st_r.compare),
		.evt(evt_bus.count_src)
	);

	always_comb
	begin
		events = '0;
		events[BIT_ADDRESS] = address_evt;
		events[BIT_PAYLOAD] = payload_evt;
		events[BIT_END] = end_evt;
		events[BIT_DISABLED] = disabled_evt;
		events[BIT_DEVICE_ADDRESS_MATCH] = device_address_match_evt;
		events[BIT_DEVICE_ADDRESS_MISS] = device_address_miss_evt;
		events[BIT_STRENGTH_SAMPLE_DONE] = evt_bus.strength_sample_done;
		events[BIT_BIT_COUNT_MATCH] = evt_bus.bit_count_match;
		events[BIT_CHECKSUM_GOOD] = checksum_good_evt;
		events[BIT_CHECKSUM_FAILED] = checksum_failed_evt;
		events[BIT_FRAME_BEGIN] = frame_begin_evt;
		events[BIT_ENERGY_DETECT_FINISHED] = energy_detect_finished_evt;
	end

	always_comb
	begin
		unique case (reg_addr)
			OFS_INTERRUPT_ENABLE_SET: rd_mux = st_r.enable;
			OFS_EVENT_STATUS: rd_mux = st_r.status;
			OFS_BIT_COUNT_COMPARE: rd_mux = st_r.compare;
			OFS_STRENGTH_SAMPLE_VALUE: rd_mux = {25'h0, evt_bus.strength_sample_value};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_comb
	begin
		st_nxt = st_r;
		if (reg_wr && reg_addr == OFS_INTERRUPT_ENABLE_SET)
		begin
			// only ones take effect; enables drop only at reset
			st_nxt.enable = st_r.enable | (reg_wdata & EVENT_MASK);
		end
		// a new event outranks a write-one clear in the same cycle
		if (reg_wr && reg_addr == OFS_EVENT_STATUS)
			st_nxt.status = (st_r.status & ~reg_wdata) | events;
		else
			st_nxt.status = st_r.status | events;
		if (reg_wr && reg_addr == OFS_BIT_COUNT_COMPARE)
			st_nxt.compare = reg_wdata;
		st_nxt.rdata = reg_rd ? rd_mux : 32'h00000000;
		st_nxt.irq = |(st_nxt.status & st_nxt.enable);
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r <= '{enable: RST_INTERRUPT_ENABLE_SET,
				status: RST_EVENT_STATUS,
				compare: RST_BIT_COUNT_COMPARE,
				rdata: 32'h00000000,
				irq: 1'b0};
		end
		else
			st_r <= st_nxt;
	end

	assign reg_rdata = st_r.rdata;
	assign irq = st_r.irq;
endmodule

//--- radio_irq_sva.sv
// checker on the radio interrupt enable register ports
`timescale 1ns/1ps
module radio_irq_sva
	import radio_irq_pkg::*;
(
	input wire logic clock, rst_n, reg_wr, reg_rd, irq,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata, reg_rdata,
	input wire logic address_evt, payload_evt, end_evt, disabled_evt,
	input wire logic device_address_match_evt, device_address_miss_evt,
	input wire logic checksum_good_evt, checksum_failed_evt, frame_begin_evt,
	input wire logic energy_detect_finished_evt, bit_count_start,
	input wire logic rx_bit_strobe, sample_strobe,
	input wire logic [6:0] sample_in
);
	// counter and sampler set status one edge late, hence the past term
	wire act = address_evt | payload_evt | end_evt | disabled_evt | device_address_match_evt
		| device_address_miss_evt | checksum_good_evt | checksum_failed_evt
		| frame_begin_evt | energy_detect_finished_evt | rx_bit_strobe | sample_strobe;
	wire w_en = reg_wr && reg_addr == 12'h304;
	wire r_en = reg_rd && reg_addr == 12'h304;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("read data not zero");
	property p_set; w_en ##1 r_en |=> (~reg_rdata & $past(reg_wdata, 2) & EVENT_MASK) == 0;
	endproperty
	a_set: assert property (p_set) else $error("enable not set");
	property p_bits; r_en |=> (reg_rdata & ~EVENT_MASK) == 32'h0; endproperty
	a_bits: assert property (p_bits) else $error("spare enable bit");
	property p_evt; w_en && reg_wdata[1] ##1 address_evt |=> irq; endproperty
	a_evt: assert property (p_evt) else $error("no interrupt");
	property p_smp; sample_strobe ##1 reg_rd && reg_addr == 12'h204
		|=> reg_rdata[6:0] == $past(sample_in, 2); endproperty
	a_smp: assert property (p_smp) else $error("bad sample");
	property p_hold; irq && !reg_wr |=> irq; endproperty
	a_hold: assert property (p_hold) else $error("interrupt dropped");
	property p_quiet; !irq && !reg_wr && !act && !$past(act) |=> !irq; endproperty
	a_quiet: assert property (p_quiet) else $error("stray interrupt");
	property p_clr; irq && reg_wr && reg_addr == 12'h100 && &reg_wdata && !act
		&& !$past(act) |=> !irq; endproperty
	a_clr: assert property (p_clr) else $error("interrupt not cleared");
	cover property (sample_strobe ##2 irq);
	cover property (rx_bit_strobe ##2 irq);
	cover property (w_en ##1 irq);
endmodule
bind radio_interrupt_enable_set radio_irq_sva u_sva (.*);

//--- testbench.sv
// self-checking bench for the radio interrupt enable register
`timescale 1ns/1ps
module testbench;
	import radio_irq_pkg::*;
	logic clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq;
	logic [11:0] reg_addr = 12'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, acc = 32'h0;
	logic [6:0] sample_in = 7'h5a;
	// events 0..9, sample, bit strobe, count start
	logic [12:0] ev = 13'h0;
	int err_count = 0, n_checks = 0;
	int bp[10] = '{1, 2, 3, 4, 5, 6, 12, 13, 14, 15};
	always #5 clock = ~clock;
	radio_interrupt_enable_set DUT (.*, .address_evt(ev[0]), .payload_evt(ev[1]),
		.end_evt(ev[2]), .disabled_evt(ev[3]), .device_address_match_evt(ev[4]),
		.device_address_miss_evt(ev[5]), .checksum_good_evt(ev[6]),
		.checksum_failed_evt(ev[7]), .frame_begin_evt(ev[8]),
		.energy_detect_finished_evt(ev[9]), .sample_strobe(ev[10]),
		.rx_bit_strobe(ev[11]), .bit_count_start(ev[12]));
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	// one cycle; strobes stay until the next call, so none is set twice per step
	task go(input logic w, r, input logic [11:0] a, input logic [31:0] d, input logic [12:0] e);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		ev <= e;
		@(posedge clock);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		go(1'b1, 1'b0, a, d, 13'h0);
	endtask
	task pl(input logic [12:0] e);
		go(1'b0, 1'b0, 12'h0, 32'h0, e);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		go(1'b0, 1'b1, a, 32'h0, 13'h0);
		#1;
		chk(reg_rdata, e);
	endtask
	task ck(input logic e);
		#1;
		chk(irq, e);
	endtask
	task test_done;
		if (err_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#100000;
		err_count++;
		test_done;
	end
	initial
	begin
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		rd(12'h304, 32'h0);
		rd(12'h100, 32'h0);
		for (int i = 0; i < 10; i++)
		begin
			acc = acc | (32'h1 << bp[i]);
			pl(13'h1 << i);
			ck(1'b0);
			rd(12'h100, 32'h1 << bp[i]);
			wr(12'h304, 32'h1 << bp[i]);
			ck(1'b1);
			wr(12'h100, 32'hffffffff);
			ck(1'b0);
			wr(12'h304, acc);
			pl(13'h1 << i);
			ck(1'b1);
			wr(12'h100, 32'hffffffff);
			wr(12'h304, 32'h0);
			rd(12'h304, acc);
		end
		pl(13'h400);
		// live input moves after the strobe; the read must still return the stored sample
		sample_in <= 7'h33;
		rd(12'h204, 32'h5a);
		rd(12'h100, 32'h80);
		wr(12'h304, 32'h80);
		ck(1'b1);
		wr(12'h100, 32'hffffffff);
		go(1'b1, 1'b0, 12'h200, 32'h3, 13'h1000);
		pl(13'h800);
		pl(13'h800);
		rd(12'h100, 32'h0);
		pl(13'h800);
		pl(13'h0);
		rd(12'h100, 32'h400);
		wr(12'h304, 32'h400);
		ck(1'b1);
		wr(12'h7fc, 32'hffffffff);
		rd(12'h7fc, 32'h0);
		wr(12'h304, 32'hffffffff);
		rd(12'h304, EVENT_MASK);
		pl(13'h0);
		test_done;
	end
endmodule
